// ==== flash_status_map.svh ====
// Purpose: field positions, opcodes, masks and reset values of the status and latch logic
// Assumes: included by its bare name; definitions only
// Notes:   bit positions are within the 16-bit status word
`ifndef FLASH_STATUS_MAP_SVH
`define FLASH_STATUS_MAP_SVH

// opcodes seen on the serial link
`define OP_WRITE_ENABLE     8'h06
`define OP_WRITE_DISABLE    8'h04
`define OP_VOLATILE_ENABLE  8'h50
`define OP_STATUS_WRITE     8'h01
`define OP_STATUS_READ_LO   8'h05
`define OP_STATUS_READ_HI   8'h35
`define OP_STATUS_READ_01   8'h15
`define OP_PAGE_PROGRAM     8'h02
`define OP_DUAL_PROGRAM     8'hA2
`define OP_QUAD_PROGRAM     8'h32
`define OP_PAGE_CLEAR       8'h81
`define OP_SECTOR_CLEAR     8'h20
`define OP_BLOCK32_CLEAR    8'h52
`define OP_BLOCK64_CLEAR    8'hD8
`define OP_CHIP_CLEAR_A     8'h60
`define OP_CHIP_CLEAR_B     8'hC7
`define OP_SEC_REG_CLEAR    8'h44
`define OP_SEC_REG_PROGRAM  8'h42
`define OP_SUSPEND_A        8'h75
`define OP_SUSPEND_B        8'hB0
`define OP_RESUME_A         8'h7A
`define OP_RESUME_B         8'h30
`define OP_RESET_ENABLE     8'h66
`define OP_RESET            8'h99

// status word field positions
`define BIT_IN_PROGRESS     0
`define BIT_LATCH           1
`define BIT_BP_LO           2
`define BIT_BP_HI           6
`define BIT_LOCK_LO_SRP     7
`define BIT_LOCK_HI_SRP     8
`define BIT_QUAD_ENABLE     9
`define BIT_PROG_SUSP       10
`define BIT_SEC_LOCK_LO     11
`define BIT_SEC_LOCK_HI     13
`define BIT_COMPLEMENT      14
`define BIT_ERASE_SUSP      15

// writable bits, one-time bits, bits kept by a one-byte write (high byte)
`define CFG_MASK            16'h7BFC
`define SEC_LOCK_MASK       16'h3800
`define ONE_BYTE_HI_KEEP    8'h38

// reset value of the stored configuration
`define CFG_RESET           16'h0000

`endif

// ==== flash_status_pkg.sv ====
// Purpose: types shared by the status and latch logic
// Assumes: nothing is imported; users write flash_status_pkg::name
// Notes:   field order matches the status word, bit 15 first
package flash_status_pkg;

	// status word as read by the host
	typedef struct packed {
		logic       erase_suspended_flag;
		logic       protect_complement;
		logic [2:0] security_lock_bits;
		logic       program_suspended_flag;
		logic       quad_enable;
		logic       status_lock_hi;
		logic       status_lock_lo;
		logic [4:0] block_protect_bits;
		logic       write_enable_latch;
		logic       write_in_progress;
	} status_word_s;

	// request to the program and erase engine
	typedef struct packed {
		logic       start;
		logic [7:0] opcode;
	} engine_req_s;

	// link sequencing
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_CMD,
		ST_READ
	} link_state_e;

	// which status read is running
	typedef enum logic [1:0] {
		RD_LO,
		RD_HI,
		RD_01
	} read_sel_e;

endpackage : flash_status_pkg

// ==== flash_status_write_latch.sv ====
// Purpose: status word, write enable latch and status opcodes of a serial multi-I/O flash
// Assumes: SPI mode 0 timing; pins are asynchronous and sampled through three flip-flops
// Notes:   program, erase and suspend engines live outside; they report busy and done here
`include "flash_status_map.svh"
`timescale 1ns/1ns

// Notes on behaviour
// - write disable opcode alone clears latch
// - latch cleared by power-up, writes, reset
// - volatile enable makes next write volatile
// - status reads allowed even while busy
// - 05h gives bits 7-0, 35h 15-8
// - 15h only in quad mode, two bits
// - bit 0 shows program/erase/write busy
// - bit 1 is latch; zero rejects writes
// - block protect bits guard array regions
// - block protect rewritable unless hardware protected
// - chip erase only with no protection
// - lock 00: writable whenever latch set
// - lock 01: pin low refuses writes
// - lock 10: refused until power cycle
// - lock 11: writes refused for ever; code refuses until reset, as for 10
// - quad enable turns pins into data
// - security lock bits one-time, then read-only; code clears them on reset
// - complement bit joins block protect selection
// - suspend sets erase or program flag
// - resume or power cycle clears flags
// - write enable opcode sets the latch
// - status write loads following data bytes
module flash_status_write_latch #(
	parameter int STATUS_WRITE_CYCLES = 5000	// self-timed status write duration
) (
	// clock and reset
	input  wire logic                        SYS_CLK_I,
	input  wire logic                        SYS_RST_I,
	// serial link pins
	input  wire logic                        CS_N_I,
	input  wire logic                        SCLK_I,
	input  wire logic [3:0]                  IO_I,
	output logic      [3:0]                  IO_O,
	output logic      [3:0]                  IO_OE_O,
	// mode from the quad mode logic
	input  wire logic                        QUAD_CMD_MODE_I,
	// program and erase engine
	input  wire logic                        ENGINE_BUSY_I,
	input  wire logic                        ENGINE_ERASING_I,
	input  wire logic                        ENGINE_DONE_I,
	output flash_status_pkg::engine_req_s    ENGINE_REQ_O,
	output logic                             SUSPEND_O,
	output logic                             RESUME_O,
	// registered status word
	output flash_status_pkg::status_word_s   STATUS_O
);

	// pin synchroniser: index 0 cs, 1 sclk, 5:2 io
	logic [5:0] pin_raw;                // raw pins
	logic [5:0] sync1;                  // first stage
	logic [5:0] sync2;                  // second stage
	logic [5:0] sync3;                  // third stage
	logic [5:0] pin_flt;                // agreed level
	logic [5:0] pin_prev;               // agreed level one cycle back

	// link decoding
	flash_status_pkg::link_state_e state;   // link phase
	flash_status_pkg::read_sel_e   rd_sel;  // active read kind
	logic [7:0]  shreg;                 // incoming shift register
	logic [7:0]  next_shreg;            // shift register after this edge
	logic [2:0]  bit_cnt;               // bits of current byte
	logic [2:0]  next_bit_cnt;          // bit count after this edge
	logic [1:0]  nbytes;                // bytes received, saturating
	logic [7:0]  opcode;                // first byte of the frame
	logic [7:0]  wdata_lo;              // first data byte
	logic [7:0]  wdata_hi;              // second data byte
	logic [2:0]  out_pos;               // next bit or nibble to drive
	logic        reset_armed;           // reset enable seen last
	logic        vol_armed;             // volatile enable seen last

	// status storage
	logic [15:0] cfg;                   // stored protect, lock, quad and complement bits
	logic [15:0] pend;                  // value waiting for write completion
	logic        write_enable_latch;    // write enable latch
	logic        sw_busy;               // status write cycle running
	logic [$clog2(STATUS_WRITE_CYCLES+1)-1:0] sw_cnt; // status write timer
	logic        erase_susp;            // erase suspended flag
	logic        prog_susp;             // program suspended flag
	logic [15:0] live;                  // status as seen now
	logic [7:0]  rd_byte;               // byte being read out

	// decoded events
	logic cs_low;                       // frame open
	logic sclk_rise;                    // data sample edge
	logic sclk_fall;                    // data drive edge
	logic cs_rise;                      // frame end
	logic cs_fall;                      // frame start
	logic byte_done;                    // byte complete this edge
	logic aligned;                      // frame ended on byte boundary
	logic cmd_only;                     // frame held opcode only
	logic wp_level;                     // write-protect function level
	logic lock_ok;                      // status lock permits writing
	logic sw_fire;                      // accepted non-volatile status write
	logic vol_fire;                     // accepted volatile status write
	logic enable_fire;                  // accepted write enable
	logic disable_fire;                 // accepted write disable
	logic rst_fire;                     // accepted software reset
	logic is_engine_op;                 // opcode needs the engine
	logic is_chip_clear;                // chip erase opcode
	logic eng_fire;                     // engine start accepted
	logic susp_fire;                    // suspend accepted
	logic res_fire;                     // resume accepted
	logic [15:0] new_word;              // value a status write would load

	assign pin_raw = {IO_I, SCLK_I, CS_N_I};

	// three-stage sampling of every pin
	always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			sync1 <= 6'h01;
			sync2 <= 6'h01;
			sync3 <= 6'h01;
		end else begin
			sync1 <= pin_raw;
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	// a change counts once stages two and three agree
	generate
		for (genvar gi = 0; gi < 6; gi++) begin : g_filter
			always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
				if (SYS_RST_I) begin
					pin_flt[gi]  <= (gi == 0);
					pin_prev[gi] <= (gi == 0);
				end else begin
					pin_prev[gi] <= pin_flt[gi];
					if (sync2[gi] == sync3[gi]) begin
						pin_flt[gi] <= sync3[gi];
					end
				end
			end
		end
	endgenerate

	// edges on the agreed levels
	assign cs_low    = !pin_flt[0];
	assign cs_fall   = pin_prev[0] && !pin_flt[0];
	assign cs_rise   = !pin_prev[0] && pin_flt[0];
	assign sclk_rise = cs_low && !pin_prev[1] && pin_flt[1];
	assign sclk_fall = cs_low && pin_prev[1] && !pin_flt[1];

	// shift path: one bit in spi, a nibble in quad mode
	always_comb begin
		if (QUAD_CMD_MODE_I) begin
			next_shreg   = {shreg[3:0], pin_flt[5:2]};
			next_bit_cnt = bit_cnt + 3'h4;
		end else begin
			next_shreg   = {shreg[6:0], pin_flt[2]};
			next_bit_cnt = bit_cnt + 3'h1;
		end
	end

	assign byte_done = sclk_rise && (next_bit_cnt == 3'h0);
	assign aligned   = (bit_cnt == 3'h0);
	assign cmd_only  = aligned && (nbytes == 2'h1);

	// byte assembly and frame bookkeeping
	always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			shreg    <= 8'h00;
			bit_cnt  <= 3'h0;
			nbytes   <= 2'h0;
			opcode   <= 8'h00;
			wdata_lo <= 8'h00;
			wdata_hi <= 8'h00;
		end else if (cs_fall) begin
			bit_cnt <= 3'h0;
			nbytes  <= 2'h0;
		end else if (sclk_rise) begin
			shreg   <= next_shreg;
			bit_cnt <= next_bit_cnt;
			if (byte_done) begin
				if (nbytes == 2'h0) begin
					opcode <= next_shreg;
				end else if (nbytes == 2'h1) begin
					wdata_lo <= next_shreg;
				end else if (nbytes == 2'h2) begin
					wdata_hi <= next_shreg;
				end
				if (nbytes != 2'h3) begin
					nbytes <= nbytes + 2'h1;
				end
			end
		end
	end

	// link phase and read selection
	always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			state  <= flash_status_pkg::ST_IDLE;
			rd_sel <= flash_status_pkg::RD_LO;
		end else begin
			case (state)
				flash_status_pkg::ST_IDLE: begin
					if (cs_fall) begin
						state <= flash_status_pkg::ST_CMD;
					end
				end
				flash_status_pkg::ST_CMD: begin
					if (cs_rise) begin
						state <= flash_status_pkg::ST_IDLE;
					end else if (byte_done && nbytes == 2'h0) begin
						// reads are honoured whatever the busy state
						if (next_shreg == `OP_STATUS_READ_LO) begin
							state  <= flash_status_pkg::ST_READ;
							rd_sel <= flash_status_pkg::RD_LO;
						end else if (next_shreg == `OP_STATUS_READ_HI) begin
							state  <= flash_status_pkg::ST_READ;
							rd_sel <= flash_status_pkg::RD_HI;
						end else if (next_shreg == `OP_STATUS_READ_01 && QUAD_CMD_MODE_I) begin
							state  <= flash_status_pkg::ST_READ;
							rd_sel <= flash_status_pkg::RD_01;
						end
					end
				end
				flash_status_pkg::ST_READ: begin
					if (cs_rise) begin
						state <= flash_status_pkg::ST_IDLE;
					end
				end
				default: begin
					state <= flash_status_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// live status word
	assign live = cfg
		| {erase_susp, 4'h0, prog_susp, 8'h00, write_enable_latch, sw_busy | ENGINE_BUSY_I};
	assign rd_byte = (rd_sel == flash_status_pkg::RD_HI) ? live[15:8] : live[7:0];

	// read-out on falling edges, msb first, repeating
	always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			IO_O    <= 4'h0;
			IO_OE_O <= 4'h0;
			out_pos <= 3'h7;
		end else if (state != flash_status_pkg::ST_READ || cs_rise) begin
			IO_OE_O <= 4'h0;
			out_pos <= (rd_sel == flash_status_pkg::RD_01 || byte_done) ? 3'h1 : 3'h7;
			if (byte_done && next_shreg != `OP_STATUS_READ_01) begin
				out_pos <= 3'h7;
			end
		end else if (sclk_fall) begin
			case (rd_sel)
				flash_status_pkg::RD_01: begin
					IO_O[0]    <= out_pos[0] ? live[`BIT_LATCH] : live[`BIT_IN_PROGRESS];
					IO_OE_O    <= 4'h1;
					out_pos    <= {2'h0, ~out_pos[0]};
				end
				default: begin
					if (QUAD_CMD_MODE_I) begin
						IO_O    <= out_pos[2] ? rd_byte[7:4] : rd_byte[3:0];
						IO_OE_O <= 4'hF;
						out_pos <= out_pos - 3'h4;
					end else begin
						IO_O[1] <= rd_byte[out_pos];
						IO_OE_O <= 4'h2;
						out_pos <= out_pos - 3'h1;
					end
				end
			endcase
		end
	end

	// write-protect pin only acts while the quad enable bit is clear
	assign wp_level = cfg[`BIT_QUAD_ENABLE] ? 1'b1 : pin_flt[4];

	// status lock modes
	always_comb begin
		case ({cfg[`BIT_LOCK_HI_SRP], cfg[`BIT_LOCK_LO_SRP]})
			2'b00:   lock_ok = 1'b1;
			2'b01:   lock_ok = wp_level;
			2'b10:   lock_ok = 1'b0;
			default: lock_ok = 1'b0;
		endcase
	end

	// value loaded by a one- or two-byte status write
	always_comb begin
		if (nbytes == 2'h2) begin
			new_word = {cfg[15:8] & `ONE_BYTE_HI_KEEP, wdata_lo};
		end else begin
			new_word = {wdata_hi, wdata_lo};
		end
		new_word = (new_word & `CFG_MASK) | (cfg & `SEC_LOCK_MASK);
	end

	// frame-end command decisions
	assign is_chip_clear = (opcode == `OP_CHIP_CLEAR_A) || (opcode == `OP_CHIP_CLEAR_B);
	assign is_engine_op  = is_chip_clear
		|| opcode == `OP_PAGE_PROGRAM || opcode == `OP_DUAL_PROGRAM
		|| opcode == `OP_QUAD_PROGRAM || opcode == `OP_PAGE_CLEAR
		|| opcode == `OP_SECTOR_CLEAR || opcode == `OP_BLOCK32_CLEAR
		|| opcode == `OP_BLOCK64_CLEAR || opcode == `OP_SEC_REG_CLEAR
		|| opcode == `OP_SEC_REG_PROGRAM;
	assign enable_fire  = cs_rise && cmd_only && opcode == `OP_WRITE_ENABLE;
	assign disable_fire = cs_rise && cmd_only && opcode == `OP_WRITE_DISABLE;
	assign rst_fire  = cs_rise && cmd_only && opcode == `OP_RESET && reset_armed;
	assign sw_fire   = cs_rise && aligned && opcode == `OP_STATUS_WRITE
		&& (nbytes == 2'h2 || nbytes == 2'h3) && !vol_armed
		&& write_enable_latch && !sw_busy && !ENGINE_BUSY_I && lock_ok;
	assign vol_fire  = cs_rise && aligned && opcode == `OP_STATUS_WRITE
		&& (nbytes == 2'h2 || nbytes == 2'h3) && vol_armed
		&& !sw_busy && !ENGINE_BUSY_I && lock_ok;
	assign eng_fire  = cs_rise && aligned && is_engine_op && write_enable_latch
		&& !sw_busy && !ENGINE_BUSY_I
		&& !(is_chip_clear && cfg[`BIT_BP_HI:`BIT_BP_LO] != 5'h00);
	assign susp_fire = cs_rise && cmd_only && ENGINE_BUSY_I
		&& (opcode == `OP_SUSPEND_A || opcode == `OP_SUSPEND_B);
	assign res_fire  = cs_rise && cmd_only
		&& (opcode == `OP_RESUME_A || opcode == `OP_RESUME_B);

	// one-shot arming by the preceding frame
	always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			vol_armed   <= 1'b0;
			reset_armed <= 1'b0;
		end else if (cs_rise && aligned && nbytes != 2'h0) begin
			vol_armed   <= cmd_only && opcode == `OP_VOLATILE_ENABLE;
			reset_armed <= cmd_only && opcode == `OP_RESET_ENABLE;
		end
	end

	// write enable latch: a set in the same cycle as a clear wins
	always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			write_enable_latch <= 1'b0;
		end else if (enable_fire) begin
			write_enable_latch <= 1'b1;
		end else if (disable_fire || rst_fire || ENGINE_DONE_I) begin
			write_enable_latch <= 1'b0;
		end else if (sw_busy && sw_cnt == '0) begin
			write_enable_latch <= 1'b0;
		end
	end

	// status storage and the self-timed status write
	always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			cfg     <= `CFG_RESET;
			pend    <= `CFG_RESET;
			sw_busy <= 1'b0;
			sw_cnt  <= '0;
		end else if (sw_fire) begin
			pend    <= new_word;
			sw_busy <= 1'b1;
			sw_cnt  <= ($clog2(STATUS_WRITE_CYCLES+1))'(STATUS_WRITE_CYCLES - 1);
		end else if (vol_fire) begin
			cfg <= new_word;
		end else if (sw_busy) begin
			if (sw_cnt == '0) begin
				cfg     <= pend;
				sw_busy <= 1'b0;
			end else begin
				sw_cnt <= sw_cnt - 1'b1;
			end
		end
	end

	// suspend flags
	always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			erase_susp <= 1'b0;
			prog_susp  <= 1'b0;
		end else if (susp_fire) begin
			erase_susp <= erase_susp | ENGINE_ERASING_I;
			prog_susp  <= prog_susp | !ENGINE_ERASING_I;
		end else if (res_fire) begin
			erase_susp <= 1'b0;
			prog_susp  <= 1'b0;
		end
	end

	// engine requests and registered status
	always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			ENGINE_REQ_O <= '0;
			SUSPEND_O    <= 1'b0;
			RESUME_O     <= 1'b0;
			STATUS_O     <= '0;
		end else begin
			ENGINE_REQ_O.start <= eng_fire;
			if (eng_fire) begin
				ENGINE_REQ_O.opcode <= opcode;
			end
			SUSPEND_O <= susp_fire;
			RESUME_O  <= res_fire;
			STATUS_O  <= live;
		end
	end

	// assertions
	default clocking cb @(posedge SYS_CLK_I); endclocking
	default disable iff (SYS_RST_I);

	sequence s_frame_end(logic [7:0] op);
		cs_rise && cmd_only && opcode == op;
	endsequence

	logic [15:0] cfg_prev;	// configuration one cycle back
	always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			cfg_prev <= `CFG_RESET;
		end else begin
			cfg_prev <= cfg;
		end
	end

	a_enable_sets: assert property (s_frame_end(`OP_WRITE_ENABLE)
		|=> write_enable_latch ##1 STATUS_O.write_enable_latch)
		else $error("write enable did not set the latch");
	a_disable_clears: assert property (s_frame_end(`OP_WRITE_DISABLE)
		|=> !write_enable_latch ##1 !STATUS_O.write_enable_latch)
		else $error("write disable did not clear the latch");
	a_done_clears: assert property (ENGINE_DONE_I && !enable_fire |=> !write_enable_latch)
		else $error("engine completion left the latch set");
	a_volatile_keeps: assert property (vol_fire
		|=> write_enable_latch == $past(write_enable_latch) && !sw_busy && cfg == $past(new_word))
		else $error("volatile write touched latch or was not applied");
	a_busy_shown: assert property (sw_fire |=> sw_busy[*2] ##1 STATUS_O.write_in_progress)
		else $error("status write did not show busy");
	a_no_latch_reject: assert property (cs_rise && opcode == `OP_STATUS_WRITE
		&& !write_enable_latch && !vol_armed |=> !sw_busy && cfg == cfg_prev)
		else $error("status write accepted without latch");
	a_chip_guard: assert property (cs_rise && aligned && is_chip_clear && cfg[6:2] != 5'h00
		|=> !ENGINE_REQ_O.start)
		else $error("chip erase started under protection");
	a_lockdown_hold: assert property (cfg[8:7] == 2'b10 && !sw_busy |=> cfg == cfg_prev)
		else $error("locked status changed");
	a_hw_protect: assert property (cfg[8:7] == 2'b01 && !wp_level |-> !sw_fire && !vol_fire)
		else $error("write allowed with protect pin low");
	a_otp_sticky: assert property ((cfg_prev & `SEC_LOCK_MASK & ~cfg) == 16'h0000)
		else $error("security lock bit cleared");
	a_resume_clears: assert property (res_fire |=> !erase_susp && !prog_susp ##1
		!STATUS_O.erase_suspended_flag && !STATUS_O.program_suspended_flag)
		else $error("resume left a suspend flag");
	a_short_spi_only: assert property (!QUAD_CMD_MODE_I && state == flash_status_pkg::ST_CMD |=> !IO_OE_O[0])
		else $error("short read answered outside quad mode");

endmodule : flash_status_write_latch

// ==== flash_host_model.sv ====
// Purpose: host side of the serial link, mode 0, spi or quad commands
// Assumes: link clock of 160 ns, moved only at system clock falls
// Notes:   released data lines toggle so no stale level is read
`timescale 1ns/1ns
module flash_host_model (
	// clock and mode
	input  wire logic       clk_i,
	input  wire logic       quad_i,
	input  wire logic       wp_n_i,
	// device pins
	input  wire logic [3:0] io_i,
	output logic            cs_n_o,
	output logic            sclk_o,
	output logic [3:0]      io_o
);
	logic [3:0] nib; // nibble or serial bit
	// hold high and wp from bench in spi mode, never tied
	assign io_o = quad_i ? nib : {1'b1, wp_n_i, ~nib[0], nib[0]};
	initial begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		nib = 4'h0;
	end
	// opcode, nw data bytes low first, then nr read clocks
	task automatic frame(input logic [7:0] op, input logic [15:0] wd, input int nw, input int nr,
		output logic [15:0] rd);
		logic [23:0] tx;
		int          nb;
		tx = {op, wd[7:0], wd[15:8]};
		nb = quad_i ? 2 + 2 * nw : 8 + 8 * nw;
		rd = 16'h0000;
		cs_n_o = 1'b0;
		repeat (8) @(negedge clk_i);
		for (int i = 0; i < nb + nr; i++) begin
			if (i >= nb) nib = ~nib;
			else if (quad_i) nib = tx[23 - 4 * i -: 4];
			else nib[0] = tx[23 - i];
			repeat (8) @(negedge clk_i);
			sclk_o = 1'b1;
			if (i >= nb) rd = {rd[14:0], quad_i ? io_i[0] : io_i[1]};
			repeat (8) @(negedge clk_i);
			sclk_o = 1'b0;
		end
		repeat (8) @(negedge clk_i);
		cs_n_o = 1'b1;
		nib = ~nib;
		repeat (8) @(negedge clk_i);
	endtask : frame
endmodule : flash_host_model

// ==== flash_status_write_latch_test.sv ====
// Purpose: self-checking bench of the status word and write latch
// Assumes: shortened status write time, host model on the link
// Notes:   the program and erase engine is played by the bench
`timescale 1ns/1ns
module flash_status_write_latch_test;
	localparam int WR_CYC = 400; // shortened write time
	logic                           clk = 1'b0;
	logic                           rst = 1'b1;
	logic                           quad = 1'b0;
	logic                           wp_n = 1'b1;
	logic                           busy = 1'b0;
	logic                           erasing = 1'b0;
	logic                           done = 1'b0;
	logic                           cs_n, sclk, susp, resm;
	logic [3:0]                     io_in, io_out, io_oe;
	logic [15:0]                    rd;
	logic [7:0]                     last_op;
	int                             num_errors, num_checks, starts, susps, resms, oe_seen;
	flash_status_pkg::engine_req_s  req;
	flash_status_pkg::status_word_s st;
	always #5 clk = ~clk;
	flash_host_model i_host (.clk_i(clk), .quad_i(quad), .wp_n_i(wp_n), .io_i(io_out),
		.cs_n_o(cs_n), .sclk_o(sclk), .io_o(io_in));
	flash_status_write_latch #(.STATUS_WRITE_CYCLES(WR_CYC)) i_dut (.SYS_CLK_I(clk), .SYS_RST_I(rst),
		.CS_N_I(cs_n), .SCLK_I(sclk), .IO_I(io_in), .IO_O(io_out), .IO_OE_O(io_oe),
		.QUAD_CMD_MODE_I(quad), .ENGINE_BUSY_I(busy), .ENGINE_ERASING_I(erasing),
		.ENGINE_DONE_I(done), .ENGINE_REQ_O(req), .SUSPEND_O(susp), .RESUME_O(resm), .STATUS_O(st));
	// count pulses and any drive on the data pins
	always @(posedge clk) begin
		if (req.start === 1'b1) begin
			starts++;
			last_op = req.opcode;
		end
		if (susp === 1'b1) susps++;
		if (resm === 1'b1) resms++;
		if (io_oe !== 4'h0) oe_seen++;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic op(input logic [7:0] c, input logic [15:0] wd = 16'h0000, input int nw = 0);
		i_host.frame(c, wd, nw, 0, rd);
	endtask : op
	// wait out a write, then read both bytes over the link
	task automatic chk_sr(input logic [15:0] exp);
		logic [15:0] lo, hi;
		for (int i = 0; i < 1000 && st.write_in_progress !== 1'b0; i++) @(negedge clk);
		i_host.frame(8'h05, 16'h0000, 0, 8, lo);
		i_host.frame(8'h35, 16'h0000, 0, 8, hi);
		chk({hi[7:0], lo[7:0]}, exp);
		chk(st, exp);
	endtask : chk_sr
	task automatic do_reset();
		rst = 1'b1;
		repeat (8) @(negedge clk);
		rst = 1'b0;
		repeat (8) @(negedge clk);
	endtask : do_reset
	task automatic t_latch();
		chk_sr(16'h0000);
		op(8'h06);
		chk_sr(16'h0002);
		op(8'h04);
		chk_sr(16'h0000);
	endtask : t_latch
	task automatic t_write();
		op(8'h01, 16'h4A1C, 2);
		chk_sr(16'h0000);
		wp_n = 1'b0;
		op(8'h06);
		op(8'h01, 16'h4A1C, 2);
		wp_n = 1'b1;
		i_host.frame(8'h05, 16'h0000, 0, 8, rd);
		chk(rd, 16'h0003);
		chk_sr(16'h4A1C);
		op(8'h06);
		op(8'h01, 16'h0000, 1);
		chk_sr(16'h0800);
		op(8'h50);
		op(8'h01, 16'h0004, 2);
		chk_sr(16'h0804);
	endtask : t_write
	task automatic t_engine();
		op(8'h06);
		op(8'h60);
		chk(16'(starts), 16'h0000);
		op(8'h50);
		op(8'h01, 16'h0000, 2);
		op(8'h04);
		op(8'hC7);
		chk(16'(starts), 16'h0000);
		for (int k = 0; k < 2; k++) begin
			op(8'h06);
			op(k ? 8'hC7 : 8'h60);
			chk({8'(starts), last_op}, k ? 16'h02C7 : 16'h0160);
			chk_sr(16'h0802);
			done = 1'b1;
			@(negedge clk);
			done = 1'b0;
			chk_sr(16'h0800);
		end
	endtask : t_engine
	task automatic t_suspend();
		busy = 1'b1;
		for (int k = 0; k < 2; k++) begin
			erasing = (k == 0);
			op(k ? 8'hB0 : 8'h75);
			chk(st, k ? 16'h0C01 : 16'h8801);
			op(k ? 8'h30 : 8'h7A);
			chk(st, 16'h0801);
		end
		chk({8'(susps), 8'(resms)}, 16'h0202);
		busy = 1'b0;
	endtask : t_suspend
	task automatic t_lock();
		op(8'h50);
		op(8'h01, 16'h0080, 2);
		wp_n = 1'b0;
		op(8'h06);
		op(8'h01, 16'h0084, 2);
		chk_sr(16'h0882);
		wp_n = 1'b1;
		op(8'h01, 16'h0084, 2);
		chk_sr(16'h0884);
		op(8'h50);
		op(8'h01, 16'h0280, 2);
		wp_n = 1'b0;
		op(8'h50);
		op(8'h01, 16'h0284, 2);
		wp_n = 1'b1;
		chk_sr(16'h0A84);
		for (int k = 0; k < 2; k++) begin
			do_reset();
			if (k) chk_sr(16'h0000);
			op(8'h50);
			op(8'h01, k ? 16'h0180 : 16'h0100, 2);
			op(8'h06);
			op(8'h01, 16'h0004, 2);
			chk_sr(k ? 16'h0182 : 16'h0102);
		end
	endtask : t_lock
	task automatic t_reads();
		op(8'h06);
		i_host.frame(8'h05, 16'h0000, 0, 16, rd);
		chk(rd, 16'h8282);
		oe_seen = 0;
		i_host.frame(8'h15, 16'h0000, 0, 8, rd);
		chk(16'(oe_seen), 16'h0000);
		quad = 1'b1;
		i_host.frame(8'h15, 16'h0000, 0, 4, rd);
		chk(rd, 16'h000A);
		i_host.frame(8'h35, 16'h0000, 0, 4, rd);
		chk(rd, 16'h0005);
		quad = 1'b0;
	endtask : t_reads
	task automatic end_of_test();
		if (num_errors == 0 && num_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : end_of_test
	initial begin
		do_reset();
		chk(st, 16'h0000);
		t_latch();
		t_write();
		t_engine();
		t_suspend();
		t_lock();
		t_reads();
		end_of_test();
	end
	// watchdog
	initial begin
		repeat (95000) @(posedge clk);
		num_errors++;
		end_of_test();
	end
endmodule : flash_status_write_latch_test
